// [rtl/iees_consts.vh]
// constants for the interrupt edge-select and enable block
// assumes a 32-bit axi4-lite register port, one register per aligned word
`ifndef IEES_CONSTS_VH
`define IEES_CONSTS_VH
// register byte offsets
`define IEES_OFF_EDGE 4'h0
`define IEES_OFF_EN1 4'h4
`define IEES_OFF_EN2 4'h8
`define IEES_OFF_FLAG1 4'hc
`define IEES_OFF_FLAG2 4'h0
`define IEES_OFF_IRQ_STAT 4'h0
`define IEES_ADDR_W 5
`define IEES_A_EDGE 5'h00
`define IEES_A_EN1 5'h04
`define IEES_A_EN2 5'h08
`define IEES_A_FLAG1 5'h0c
`define IEES_A_FLAG2 5'h10
`define IEES_A_STAT 5'h14
`define IEES_A_MASK 5'h18
// reset values, fixed edge bits and edge write mask
`define IEES_EDGE_RST 8'he0
`define IEES_EN_RST 8'h00
`define IEES_EDGE_FIXED 8'he0
`define IEES_EDGE_WMASK 8'h1f
// first enable register fields
`define IEES_EN1_TIMER_A 7
`define IEES_EN1_SERIAL 6
`define IEES_EN1_WAKEUP 5
// second enable register fields
`define IEES_EN2_DIRECT 7
`define IEES_EN2_CONV 6
`define IEES_EN2_TIMER_G 4
`define IEES_EN2_TF_HIGH 3
`define IEES_EN2_TF_LOW 2
// second flag register keeps only these bits
`define IEES_FLAG2_MASK 8'hdc
// axi responses
`define IEES_RESP_OKAY 2'b00
`define IEES_RESP_SLVERR 2'b10
`endif

// [rtl/iees_top.v]
// interrupt edge selection, request flags and enable gating
// assumes synchronous inputs on ref_clk_i and an axi4-lite master
// register map, byte addresses, data in bits 7:0
// 0x00 edge select, bits 7..5 fixed high
// 0x04 first enable
// 0x08 second enable, bits 5, 1 and 0 only store
// 0x0c pin flags, write 0 clears, 1 keeps
// 0x14 status, cleared by the read itself
// 0x18 mask over the status bits
// other words answer with slverr
`include "iees_consts.vh"
module iees_top (
   // clock and reset
   input wire ref_clk_i,
   input wire rst_b_i,
   // axi4-lite write address and data
   input wire [`IEES_ADDR_W-1:0] s_axi_awaddr_i,
   input wire s_axi_awvalid_i,
   output reg s_axi_awready_o,
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0] s_axi_wstrb_i,
   input wire s_axi_wvalid_i,
   output reg s_axi_wready_o,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp_o,
   output reg s_axi_bvalid_o,
   input wire s_axi_bready_i,
   // axi4-lite read
   input wire [`IEES_ADDR_W-1:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   output reg s_axi_arready_o,
   output reg [31:0] s_axi_rdata_o,
   output reg [1:0] s_axi_rresp_o,
   output reg s_axi_rvalid_o,
   input wire s_axi_rready_i,
   // external request pins and the edge-sensed timer event inputs
   input wire [4:0] external_request_pin_i,
   input wire timer_f_event_input_i,
   input wire timer_c_event_input_i,
   // peripheral request levels, already flagged at their source
   input wire timer_a_req_i,
   input wire serial_unit_one_req_i,
   input wire wakeup_pin_req_i,
   input wire direct_transfer_req_i,
   input wire converter_req_i,
   input wire timer_g_req_i,
   input wire timer_f_high_req_i,
   input wire timer_f_low_req_i,
   // detected edges for the timers, and gated requests to the core
   output reg timer_f_edge_o,
   output reg timer_c_edge_o,
   output reg [4:0] external_request_o,
   output reg timer_a_req_o,
   output reg serial_unit_one_req_o,
   output reg wakeup_req_o,
   output reg direct_transfer_req_o,
   output reg converter_req_o,
   output reg timer_g_req_o,
   output reg timer_f_high_req_o,
   output reg timer_f_low_req_o,
   output reg irq_o
);

   reg [7:0] edge_pol_q;
   reg [7:0] enable_first_q;
   reg [7:0] enable_second_q;
   reg [4:0] pin_flag_q;
   reg [4:0] pin_prev_q;
   reg tf_prev_q;
   reg tc_prev_q;
   reg [1:0] stat_q;
   reg [1:0] mask_q;
   reg [`IEES_ADDR_W-1:0] aw_addr_q;
   reg aw_have_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_have_q;

   wire [4:0] pin_edge;
   wire [4:0] flag_clr;
   wire wr_fire;
   wire wr_hit;
   wire rd_fire;
   wire edge_pol_three;
   wire edge_pol_one;
   wire tf_edge;
   wire tc_edge;
   wire [1:0] stat_set;
   wire [1:0] stat_rd_clr;
   wire req_any;

   assign edge_pol_three = edge_pol_q[3];
   assign edge_pol_one = edge_pol_q[1];

   // per-pin edge detect: falling when polarity bit is 0, rising when 1
   // the compare runs against last cycle's sample, so a pulse must be
   // at least one clock wide to be seen at all
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_pin
         assign pin_edge[gi] = edge_pol_q[gi] ?
            (external_request_pin_i[gi] & ~pin_prev_q[gi]) :
            (~external_request_pin_i[gi] & pin_prev_q[gi]);
      end
   endgenerate

   // timer event inputs share polarity with pins 3 and 1
   // only the edge goes out; any counting stays with the timers
   assign tf_edge = edge_pol_three ?
      (timer_f_event_input_i & ~tf_prev_q) :
      (~timer_f_event_input_i & tf_prev_q);
   assign tc_edge = edge_pol_one ?
      (timer_c_event_input_i & ~tc_prev_q) :
      (~timer_c_event_input_i & tc_prev_q);

   // write fires once address and data are both held
   // a response still waiting holds the next write back
   assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid_o;
   // status takes a write without effect, so it still answers okay
   assign wr_hit = (aw_addr_q == `IEES_A_EDGE) |
      (aw_addr_q == `IEES_A_EN1) | (aw_addr_q == `IEES_A_EN2) |
      (aw_addr_q == `IEES_A_FLAG1) | (aw_addr_q == `IEES_A_MASK) |
      (aw_addr_q == `IEES_A_STAT);
   assign rd_fire = s_axi_arvalid_i & s_axi_arready_o;

   // writing 0 to a flag bit clears it, writing 1 leaves it
   // only byte lane 0 carries the flags; other lanes are ignored
   assign flag_clr = (wr_fire && aw_addr_q == `IEES_A_FLAG1 && w_strb_q[0])
      ? ~w_data_q[4:0] : 5'h00;

   // sticky events: bit0 any pin flag raised, bit1 any timer edge seen
   // the read clears at address acceptance, before the data goes out,
   // so the returned word is the state that was cleared
   assign stat_set = {tf_edge | tc_edge, |pin_edge};
   assign stat_rd_clr = (rd_fire && s_axi_araddr_i == `IEES_A_STAT) ?
      2'b11 : 2'b00;
   // interrupt level: any unmasked status bit
   assign req_any = |(stat_q & mask_q);

   // edge history registers
   // polarity resets to falling, so a low history gives no false edge
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_prev_q <= 5'h00;
         tf_prev_q <= 1'b0;
         tc_prev_q <= 1'b0;
      end else begin
         pin_prev_q <= external_request_pin_i;
         tf_prev_q <= timer_f_event_input_i;
         tc_prev_q <= timer_c_event_input_i;
      end
   end
   // note: the history resets low, so a pin held low at release
   // is not taken as a falling edge, and one held high gives no edge either

   // pin flags: set wins over a clear in the same cycle
   // otherwise an edge landing with the clear would be lost
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_flag_q <= 5'h00;
      end else begin
         pin_flag_q <= (pin_flag_q & ~flag_clr) | pin_edge;
      end
   end

   // control registers and interrupt status
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         edge_pol_q <= `IEES_EDGE_RST;
         enable_first_q <= `IEES_EN_RST;
         enable_second_q <= `IEES_EN_RST;
         mask_q <= 2'b00;
         stat_q <= 2'b00;
      end else begin
         // hardware set wins over a read clear
         stat_q <= (stat_q & ~stat_rd_clr) | stat_set;
         // a write without lane 0 is answered but changes nothing
         if (wr_fire && w_strb_q[0]) begin
            case (aw_addr_q)
               // bits 4..0 set the pin edge polarities; bits 7..5 stay fixed high
               `IEES_A_EDGE: begin
                  edge_pol_q <= `IEES_EDGE_FIXED |
                     (w_data_q[7:0] & `IEES_EDGE_WMASK);
               end
               `IEES_A_EN1: begin
                  enable_first_q <= w_data_q[7:0];
               end
               `IEES_A_EN2: begin
                  enable_second_q <= w_data_q[7:0];
               end
               `IEES_A_MASK: begin
                  mask_q <= w_data_q[1:0];
               end
               default: begin
                  mask_q <= mask_q;
               end
            endcase
         end
      end
   end

   // gated requests: flag and enable both high
   // every output leaves a flop, at the cost of one cycle of latency
   // between a source or enable change and the core
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         external_request_o <= 5'h00;
         timer_a_req_o <= 1'b0;
         serial_unit_one_req_o <= 1'b0;
         wakeup_req_o <= 1'b0;
         direct_transfer_req_o <= 1'b0;
         converter_req_o <= 1'b0;
         timer_g_req_o <= 1'b0;
         timer_f_high_req_o <= 1'b0;
         timer_f_low_req_o <= 1'b0;
         timer_f_edge_o <= 1'b0;
         timer_c_edge_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         external_request_o <= pin_flag_q & enable_first_q[4:0];
         timer_a_req_o <= timer_a_req_i &
            enable_first_q[`IEES_EN1_TIMER_A];
         serial_unit_one_req_o <= serial_unit_one_req_i &
            enable_first_q[`IEES_EN1_SERIAL];
         wakeup_req_o <= wakeup_pin_req_i &
            enable_first_q[`IEES_EN1_WAKEUP];
         direct_transfer_req_o <= direct_transfer_req_i &
            enable_second_q[`IEES_EN2_DIRECT];
         converter_req_o <= converter_req_i &
            enable_second_q[`IEES_EN2_CONV];
         timer_g_req_o <= timer_g_req_i &
            enable_second_q[`IEES_EN2_TIMER_G];
         timer_f_high_req_o <= timer_f_high_req_i &
            enable_second_q[`IEES_EN2_TF_HIGH];
         timer_f_low_req_o <= timer_f_low_req_i &
            enable_second_q[`IEES_EN2_TF_LOW];
         timer_f_edge_o <= tf_edge;
         timer_c_edge_o <= tc_edge;
         irq_o <= req_any;
      end
   end

   // axi write channel: capture address and data in either order
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= {`IEES_ADDR_W{1'b0}};
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= `IEES_RESP_OKAY;
      end else begin
         // readies pulse while idle; held low while a word is captured
         // or a response waits, so a second write cannot slip in
         s_axi_awready_o <= ~aw_have_q & ~s_axi_awready_o &
            ~s_axi_bvalid_o & ~wr_fire;
         s_axi_wready_o <= ~w_have_q & ~s_axi_wready_o &
            ~s_axi_bvalid_o & ~wr_fire;
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata_i;
            w_strb_q <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
         end
         // response carries okay only for a mapped word
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_hit ? `IEES_RESP_OKAY : `IEES_RESP_SLVERR;
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // axi read channel: one read at a time, data registered
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0000_0000;
         s_axi_rresp_o <= `IEES_RESP_OKAY;
      end else begin
         // arready pulses while idle and stays low until the data
         // has been taken, so only one read is ever under way
         s_axi_arready_o <= ~s_axi_rvalid_o & ~s_axi_arready_o &
            ~rd_fire;
         if (rd_fire) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= `IEES_RESP_OKAY;
            case (s_axi_araddr_i)
               `IEES_A_EDGE: s_axi_rdata_o <= {24'h000000, edge_pol_q};
               `IEES_A_EN1: s_axi_rdata_o <= {24'h000000, enable_first_q};
               `IEES_A_EN2: s_axi_rdata_o <= {24'h000000, enable_second_q};
               `IEES_A_FLAG1: s_axi_rdata_o <= {27'h0, pin_flag_q};
               `IEES_A_STAT: s_axi_rdata_o <= {30'h0, stat_q};
               `IEES_A_MASK: s_axi_rdata_o <= {30'h0, mask_q};
               // unmapped words read zero so nothing stale leaks out
               default: begin
                  s_axi_rdata_o <= 32'h0000_0000;
                  s_axi_rresp_o <= `IEES_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end

endmodule // iees_top

// [tb/iees_monitor.sv]
// checker for the edge-select and enable block
// sees only top-level ports; bound to iees_top below
module iees_monitor (
   // clock and reset
   input wire ref_clk_i,
   input wire rst_b_i,
   // bus handshake
   input wire s_axi_awready_o,
   input wire s_axi_bvalid_o,
   input wire s_axi_bready_i,
   input wire [1:0] s_axi_bresp_o,
   input wire s_axi_rvalid_o,
   input wire s_axi_rready_i,
   input wire [31:0] s_axi_rdata_o,
   // edge inputs and pulses
   input wire timer_f_event_input_i,
   input wire timer_c_event_input_i,
   input wire timer_f_edge_o,
   input wire timer_c_edge_o,
   // gated requests
   input wire timer_a_req_i,
   input wire timer_a_req_o,
   input wire wakeup_pin_req_i,
   input wire wakeup_req_o,
   input wire converter_req_i,
   input wire converter_req_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   // a gated request only follows a raised source, one cycle late
   ta_gate_a: assert property (timer_a_req_o |-> $past(timer_a_req_i))
      else $error("timer a request without source");
   wk_gate_a: assert property (wakeup_req_o |-> $past(wakeup_pin_req_i))
      else $error("wakeup request without source");
   cv_gate_a: assert property (converter_req_o |-> $past(converter_req_i))
      else $error("converter request without source");
   // a pulse stands exactly one cycle after the input moved
   tf_edge_a: assert property (timer_f_edge_o |->
      $past(timer_f_event_input_i) != $past(timer_f_event_input_i, 2))
      else $error("timer f pulse without input change");
   tc_edge_a: assert property (timer_c_edge_o |->
      $past(timer_c_event_input_i) != $past(timer_c_event_input_i, 2))
      else $error("timer c pulse without input change");
   // responses stand until taken, so register data cannot be lost
   b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
      s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bvalid dropped");
   r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rvalid dropped");
   aw_busy_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
      else $error("write address taken while response pending");
endmodule // iees_monitor

bind iees_top iees_monitor iees_monitor_i (.ref_clk_i(ref_clk_i),
   .rst_b_i(rst_b_i), .s_axi_awready_o(s_axi_awready_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
   .s_axi_bresp_o(s_axi_bresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
   .timer_f_event_input_i(timer_f_event_input_i),
   .timer_c_event_input_i(timer_c_event_input_i),
   .timer_f_edge_o(timer_f_edge_o), .timer_c_edge_o(timer_c_edge_o),
   .timer_a_req_i(timer_a_req_i), .timer_a_req_o(timer_a_req_o),
   .wakeup_pin_req_i(wakeup_pin_req_i), .wakeup_req_o(wakeup_req_o),
   .converter_req_i(converter_req_i), .converter_req_o(converter_req_o));

// [tb/iees_partner.sv]
// peripheral request sources: sticky flags raised and dropped by the bench
// assumes raise and drop are driven off the clock edge
module iees_partner (
   // clock and reset
   input wire ref_clk_i,
   input wire rst_b_i,
   // flag control
   input wire [7:0] raise_i,
   input wire [7:0] drop_i,
   output logic [7:0] flag_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // flags hold until dropped, like source flags cleared by software
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) flag_o <= 8'h00;
      else flag_o <= (flag_o | raise_i) & ~drop_i;
   end
endmodule // iees_partner

// [tb/interrupt_enable_edge_select_test.sv]
// self-checking bench for iees_top with a register model
// assumes the design answers every bus request within 40 cycles
`include "iees_consts.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module interrupt_enable_edge_select_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 0, rst_b_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
   logic s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
   logic [4:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, pin = 0;
   logic [31:0] s_axi_wdata_i = 0, q;
   logic tfe = 0, tce = 0;
   logic [7:0] up = 0, dn = 0, fl, e1, e2, r;
   logic [1:0] rs, ws;
   wire [7:0] go;
   wire [4:0] xo;
   wire irq, tfo, tco, awr, wr_, bv, arr, rv;
   wire [1:0] br, rr;
   wire [31:0] rdat;
   int failures = 0, cmp_count = 0, tf_n = 0, tc_n = 0, nf, nc;
   always #2.5 ref_clk_i = ~ref_clk_i;
   // count timer edge pulses as they appear
   always @(posedge ref_clk_i) begin
      tf_n += tfo;
      tc_n += tco;
   end
   iees_partner iees_partner_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .raise_i(up), .drop_i(dn), .flag_o(fl));
   iees_top iees_top_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
      .s_axi_awready_o(awr), .s_axi_wdata_i(s_axi_wdata_i),
      .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(s_axi_wvalid_i),
      .s_axi_wready_o(wr_), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
      .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(s_axi_rready_i), .external_request_pin_i(pin),
      .timer_f_event_input_i(tfe), .timer_c_event_input_i(tce),
      .timer_a_req_i(fl[7]), .serial_unit_one_req_i(fl[6]),
      .wakeup_pin_req_i(fl[5]), .direct_transfer_req_i(fl[4]),
      .converter_req_i(fl[3]), .timer_g_req_i(fl[2]),
      .timer_f_high_req_i(fl[1]), .timer_f_low_req_i(fl[0]),
      .timer_f_edge_o(tfo), .timer_c_edge_o(tco), .external_request_o(xo),
      .timer_a_req_o(go[7]), .serial_unit_one_req_o(go[6]),
      .wakeup_req_o(go[5]), .direct_transfer_req_o(go[4]),
      .converter_req_o(go[3]), .timer_g_req_o(go[2]),
      .timer_f_high_req_o(go[1]), .timer_f_low_req_o(go[0]), .irq_o(irq));
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // write: address and data together, bready once bvalid is seen
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      int n;
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= {24'h0, v};
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge ref_clk_i);
         if (awr) s_axi_awvalid_i <= 1'b0;
         if (wr_) s_axi_wvalid_i <= 1'b0;
         if (s_axi_bready_i && bv) break;
         if (bv) s_axi_bready_i <= 1'b1;
      end
      ws = br;
      s_axi_bready_i <= 1'b0;
      if (n == 40) begin
         failures++;
         wrap_up();
      end
   endtask
   // read: data and response taken at the handshake edge
   task automatic rd(input logic [4:0] a);
      int n;
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge ref_clk_i);
         if (arr) s_axi_arvalid_i <= 1'b0;
         if (s_axi_rready_i && rv) break;
         if (rv) s_axi_rready_i <= 1'b1;
      end
      q = rdat;
      rs = rr;
      s_axi_rready_i <= 1'b0;
      if (n == 40) begin
         failures++;
         wrap_up();
      end
   endtask
   initial begin
      void'($urandom(22444));
      repeat (4) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      @(posedge ref_clk_i);
      // reset values and an unmapped word
      rd(`IEES_A_EDGE);
      `CHK(q, 32'h0000_00e0)
      rd(`IEES_A_EN1);
      `CHK(q, 32'h0)
      rd(`IEES_A_EN2);
      `CHK(q, 32'h0)
      rd(5'h1c);
      `CHK(rs, `IEES_RESP_SLVERR)
      wr(5'h1c, 8'hff);
      `CHK(ws, `IEES_RESP_SLVERR)
      // random enables against random source flags
      repeat (6) begin
         e1 = $urandom;
         e2 = $urandom;
         r = $urandom;
         wr(`IEES_A_EN1, e1);
         wr(`IEES_A_EN2, e2);
         wr(`IEES_A_EDGE, e2);
         `CHK(ws, `IEES_RESP_OKAY)
         rd(`IEES_A_EN1);
         `CHK(q, {24'h0, e1})
         rd(`IEES_A_EN2);
         `CHK(q, {24'h0, e2})
         rd(`IEES_A_EDGE);
         `CHK(q, {24'h0, 8'he0 | (e2 & 8'h1f)})
         up <= r;
         dn <= ~r;
         @(posedge ref_clk_i);
         up <= 8'h00;
         dn <= 8'h00;
         repeat (3) @(posedge ref_clk_i);
         `CHK(go, r & {e1[7:5], e2[7:6], e2[4:2]})
      end
      // every pin and both polarities; the selected edge flags just that pin, and the timer f and c inputs, moved with pins 3 and 1, pulse once
      wr(`IEES_A_EN1, 8'h1f);
      for (int i = 0; i < 5; i++) begin
         for (int p = 0; p < 2; p++) begin
            wr(`IEES_A_EDGE, 8'(p) << i);
            pin <= 5'(p == 0) << i;
            tfe <= (i == 3) && (p == 0);
            tce <= (i == 1) && (p == 0);
            repeat (3) @(posedge ref_clk_i);
            wr(`IEES_A_FLAG1, 8'h00);
            nf = tf_n;
            nc = tc_n;
            pin <= 5'(p) << i;
            tfe <= (i == 3) && (p == 1);
            tce <= (i == 1) && (p == 1);
            repeat (3) @(posedge ref_clk_i);
            `CHK(xo, 5'h01 << i)
            `CHK(tf_n - nf, int'(i == 3))
            `CHK(tc_n - nc, int'(i == 1))
            rd(`IEES_A_FLAG1);
            `CHK(q[4:0], 5'h01 << i)
         end
      end
      // clearing the enables withdraws requests, flags stay
      wr(`IEES_A_EN1, 8'h00);
      repeat (2) @(posedge ref_clk_i);
      `CHK(xo, 5'h00)
      rd(`IEES_A_FLAG1);
      `CHK(q[4:0], 5'h10)
      // status, mask and the interrupt line on pin 0 falling edges
      wr(`IEES_A_MASK, 8'h01);
      pin <= 5'h01;
      repeat (3) @(posedge ref_clk_i);
      rd(`IEES_A_STAT);
      repeat (2) @(posedge ref_clk_i);
      `CHK(irq, 1'b0)
      pin <= 5'h00;
      repeat (3) @(posedge ref_clk_i);
      `CHK(irq, 1'b1)
      rd(`IEES_A_STAT);
      `CHK(q[0], 1'b1)
      repeat (2) @(posedge ref_clk_i);
      `CHK(irq, 1'b0)
      wr(`IEES_A_MASK, 8'h00);
      pin <= 5'h01;
      @(posedge ref_clk_i);
      pin <= 5'h00;
      repeat (3) @(posedge ref_clk_i);
      `CHK(irq, 1'b0)
      // reset again in mid-run: the first enable must read zero
      rst_b_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      @(posedge ref_clk_i);
      rd(`IEES_A_EN1);
      `CHK(q, 32'h0)
      wrap_up();
   end
endmodule // interrupt_enable_edge_select_test
